// File: hw/suspend_plane_map.svh
// Register offsets, field positions, reset values and timing counts for the
// suspend plane and status output block.
// Assumes inclusion by bare name from the design module.
`ifndef SUSPEND_PLANE_MAP_SVH
`define SUSPEND_PLANE_MAP_SVH

// Word byte offsets on the Avalon-MM register bus.
`define SPO_OFS_CTRL 8'h00
`define SPO_OFS_THROTTLE 8'h04
`define SPO_OFS_PINSEL 8'h08
`define SPO_OFS_GPO 8'h34
`define SPO_OFS_GPI 8'h30
`define SPO_OFS_STATUS 8'h0C
`define SPO_OFS_MASK 8'h10
`define SPO_OFS_STATE 8'h14

// Control register fields.
`define SPO_CTRL_THERM_EN 0
`define SPO_CTRL_ALERT_EN 1
`define SPO_CTRL_RESET 32'h0000_0000

// Pin selection fields: one means the pin serves its general-purpose use.
`define SPO_SEL_SECONDARY 0
`define SPO_SEL_TERTIARY 1
`define SPO_SEL_HOSTCLK 2
`define SPO_SEL_SYSSUSP 3
`define SPO_SEL_SRAM 4
`define SPO_SEL_ALERT_GPI 5
`define SPO_SEL_THERM_GPI 6
`define SPO_PINSEL_RESET 32'h0000_0000

// General-purpose output bit positions.
`define SPO_GPO_FIFTEEN 15
`define SPO_GPO_SIXTEEN 16
`define SPO_GPO_NINETEEN 19
`define SPO_GPO_TWENTY 20
`define SPO_GPO_TWENTYONE 21
`define SPO_GPO_RESET 32'h0000_0000

// General-purpose input bit positions.
`define SPO_GPI_EIGHT 8
`define SPO_GPI_ELEVEN 11

// Status and mask fields.
`define SPO_ST_ALERT 0
`define SPO_ST_THERM 1
`define SPO_ST_WIDTH 2
`define SPO_MASK_RESET 2'h0

// Throttle half period minus one, in clock cycles, reset value.
`define SPO_THROTTLE_RESET 16'h0100

`endif

// File: hw/suspend_plane_pkg.sv
// Types shared by the suspend plane and status output block.
// Assumes the map header is on the include path.
package suspend_plane_pkg;

    // Suspend states supplied by the suspend sequencer.
    typedef enum logic [2:0] {
        ST_ON,
        ST_STOP_CLOCK,
        ST_POWER_ON_SUSPEND,
        ST_SUSPEND_TO_RAM,
        ST_SUSPEND_TO_DISK
    } suspend_state_t;

    // Pin function selections held in the pin select register.
    typedef struct packed {
        logic therm_gpi;
        logic alert_gpi;
        logic sram_gpo;
        logic syssusp_gpo;
        logic hostclk_gpo;
        logic tertiary_gpo;
        logic secondary_gpo;
    } pin_select_t;

    // Plane and status outputs travelling together; active low except sram_sleep.
    typedef struct packed {
        logic primary_n;
        logic secondary_n;
        logic tertiary_n;
        logic hostclk_n;
        logic syssusp_n;
        logic sram_sleep;
    } plane_out_t;

endpackage

// File: hw/suspend_plane_status_outputs.sv
// Suspend power plane controls, suspend status outputs, cache SRAM sleep,
// thermal clock throttling and bus alert event logic.
// Assumes the suspend state arrives on CLK from the suspend sequencer and
// that thermal and alert pins are asynchronous to CLK.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "suspend_plane_map.svh"

module suspend_plane_status_outputs (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [2:0] SUSPEND_STATE,
    input wire logic THERMAL_DETECT_N,
    input wire logic BUS_ALERT_N,
    input wire logic SMB_CLK_IN,
    input wire logic SMB_DATA_IN,
    output logic SMB_CLK_OUT,
    output logic SMB_CLK_OE_N,
    output logic SMB_DATA_OUT,
    output logic SMB_DATA_OE_N,
    output logic PRIMARY_PLANE_CTL_N,
    output logic SECONDARY_PLANE_CTL_N,
    output logic TERTIARY_PLANE_CTL_N,
    output logic HOST_CLOCK_STATUS_N,
    output logic SYSTEM_SUSPEND_STATUS_N,
    output logic CACHE_SRAM_SLEEP,
    output logic CPU_STOP_CLOCK_REQ_N,
    output logic THROTTLE_ACTIVE,
    output logic ALERT_EVENT,
    output logic IRQ
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic therm_meta_ff;
    logic therm_sync_ff;
    logic alert_meta_ff;
    logic alert_sync_ff;

    // Two flops per asynchronous pin before any logic looks at it.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            therm_meta_ff <= 1'b1;
            therm_sync_ff <= 1'b1;
            alert_meta_ff <= 1'b1;
            alert_sync_ff <= 1'b1;
        end else begin
            therm_meta_ff <= THERMAL_DETECT_N;
            therm_sync_ff <= therm_meta_ff;
            alert_meta_ff <= BUS_ALERT_N;
            alert_sync_ff <= alert_meta_ff;
        end
    end

    // ==========================================================
    // Register bus decode
    // ==========================================================
    logic [31:0] ctrl_ff;
    logic [31:0] pinsel_ff;
    logic [31:0] gpo_ff;
    logic [15:0] rate_ff;
    logic [`SPO_ST_WIDTH-1:0] status_ff;
    logic [`SPO_ST_WIDTH-1:0] mask_ff;
    logic [31:0] rdata_ff;
    logic rd_done_ff;

    wire hit_ctrl = AVS_ADDRESS == `SPO_OFS_CTRL;
    wire hit_rate = AVS_ADDRESS == `SPO_OFS_THROTTLE;
    wire hit_pinsel = AVS_ADDRESS == `SPO_OFS_PINSEL;
    wire hit_gpo = AVS_ADDRESS == `SPO_OFS_GPO;
    wire hit_gpi = AVS_ADDRESS == `SPO_OFS_GPI;
    wire hit_status = AVS_ADDRESS == `SPO_OFS_STATUS;
    wire hit_mask = AVS_ADDRESS == `SPO_OFS_MASK;
    wire hit_state = AVS_ADDRESS == `SPO_OFS_STATE;
    wire wr_en = AVS_WRITE;

    // Byte-lane merge used by the control, pin select, output and throttle words.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] wmerged_ctrl = merge(ctrl_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] wmerged_sel = merge(pinsel_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] wmerged_gpo = merge(gpo_ff, AVS_WRITEDATA, AVS_BYTEENABLE);
    wire [31:0] wmerged_rate = merge({16'h0000, rate_ff}, AVS_WRITEDATA,
                                     AVS_BYTEENABLE);

    // Writes complete at once; reads wait one cycle for registered data.
    assign AVS_WAITREQUEST = AVS_READ & ~rd_done_ff;
    assign AVS_READDATA = rdata_ff;

    // ==========================================================
    // Configuration registers
    // ==========================================================
    wire therm_en = ctrl_ff[`SPO_CTRL_THERM_EN];
    wire alert_en = ctrl_ff[`SPO_CTRL_ALERT_EN];
    suspend_plane_pkg::pin_select_t sel;
    assign sel = pinsel_ff[6:0];

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctrl_ff <= `SPO_CTRL_RESET;
            pinsel_ff <= `SPO_PINSEL_RESET;
            rate_ff <= `SPO_THROTTLE_RESET;
            mask_ff <= `SPO_MASK_RESET;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl_ff <= wmerged_ctrl;
            if (hit_pinsel) pinsel_ff <= wmerged_sel;
            if (hit_rate) rate_ff <= wmerged_rate[15:0];
            if (hit_mask) mask_ff <= AVS_WRITEDATA[`SPO_ST_WIDTH-1:0];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            gpo_ff <= `SPO_GPO_RESET;
        end else if (wr_en && hit_gpo) begin
            gpo_ff <= wmerged_gpo;
        end
    end

    // ==========================================================
    // Suspend state decode
    // ==========================================================
    suspend_plane_pkg::suspend_state_t state;
    assign state = suspend_plane_pkg::suspend_state_t'(SUSPEND_STATE);
    wire in_pos = state == suspend_plane_pkg::ST_POWER_ON_SUSPEND;
    wire in_str = state == suspend_plane_pkg::ST_SUSPEND_TO_RAM;
    wire in_std = state == suspend_plane_pkg::ST_SUSPEND_TO_DISK;
    wire in_cpu_stop_clock_req_n = state == suspend_plane_pkg::ST_STOP_CLOCK;
    wire any_susp = in_pos | in_str | in_std;

    // ==========================================================
    // Thermal throttle
    // ==========================================================
    logic [15:0] thr_cnt_ff;
    logic stp_ff;
    // Thermal pin only throttles when not a general input.
    wire throttle = therm_en & ~sel.therm_gpi & ~therm_sync_ff;
    wire thr_wrap = thr_cnt_ff >= rate_ff;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            thr_cnt_ff <= 16'h0000;
            stp_ff <= 1'b0;
        end else if (!throttle) begin
            thr_cnt_ff <= 16'h0000;
            stp_ff <= 1'b0;
        end else if (thr_wrap) begin
            thr_cnt_ff <= 16'h0000;
            stp_ff <= ~stp_ff;
        end else begin
            thr_cnt_ff <= thr_cnt_ff + 16'h0001;
        end
    end

    wire cpu_stopped = in_cpu_stop_clock_req_n | stp_ff;

    // ==========================================================
    // Plane and status outputs
    // ==========================================================
    suspend_plane_pkg::plane_out_t nxt_out;
    suspend_plane_pkg::plane_out_t out_ff;

    assign nxt_out.primary_n = ~any_susp;
    assign nxt_out.secondary_n = sel.secondary_gpo ?
        gpo_ff[`SPO_GPO_FIFTEEN] : ~(in_str | in_std);
    assign nxt_out.tertiary_n = sel.tertiary_gpo ?
        gpo_ff[`SPO_GPO_SIXTEEN] : ~in_std;
    assign nxt_out.hostclk_n = sel.hostclk_gpo ?
        gpo_ff[`SPO_GPO_TWENTY] : ~(cpu_stopped | any_susp);
    assign nxt_out.syssusp_n = sel.syssusp_gpo ?
        gpo_ff[`SPO_GPO_TWENTYONE] : ~any_susp;
    assign nxt_out.sram_sleep = sel.sram_gpo ?
        gpo_ff[`SPO_GPO_NINETEEN] : cpu_stopped & ~any_susp;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            out_ff <= '0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign PRIMARY_PLANE_CTL_N = out_ff.primary_n;
    assign SECONDARY_PLANE_CTL_N = out_ff.secondary_n;
    assign TERTIARY_PLANE_CTL_N = out_ff.tertiary_n;
    assign HOST_CLOCK_STATUS_N = out_ff.hostclk_n;
    assign SYSTEM_SUSPEND_STATUS_N = out_ff.syssusp_n;
    assign CACHE_SRAM_SLEEP = out_ff.sram_sleep;
    assign CPU_STOP_CLOCK_REQ_N = ~stp_ff;
    assign THROTTLE_ACTIVE = throttle;

    // ==========================================================
    // Bus pins
    // ==========================================================
    // Bus pins undriven.
    assign SMB_CLK_OUT = 1'b0;
    assign SMB_CLK_OE_N = 1'b1;
    assign SMB_DATA_OUT = 1'b0;
    assign SMB_DATA_OE_N = 1'b1;

    // ==========================================================
    // Events and interrupt
    // ==========================================================
    logic alert_prev_ff;
    logic therm_prev_ff;
    wire alert_set = alert_en & ~sel.alert_gpi & alert_prev_ff
                     & ~alert_sync_ff;
    wire therm_set = throttle & therm_prev_ff;
    wire [`SPO_ST_WIDTH-1:0] ev_set = {therm_set, alert_set};
    wire [`SPO_ST_WIDTH-1:0] ev_clr = (wr_en && hit_status) ?
        AVS_WRITEDATA[`SPO_ST_WIDTH-1:0] : '0;

    // Set wins over a same-cycle write-one-to-clear.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            alert_prev_ff <= 1'b1;
            therm_prev_ff <= 1'b1;
            status_ff <= '0;
            ALERT_EVENT <= 1'b0;
        end else begin
            alert_prev_ff <= alert_sync_ff;
            therm_prev_ff <= ~throttle;
            status_ff <= (status_ff & ~ev_clr) | ev_set;
            ALERT_EVENT <= alert_set;
        end
    end

    assign IRQ = |(status_ff & mask_ff);

    // ==========================================================
    // Read data
    // ==========================================================
    wire [31:0] gpi_word = ({31'h0, therm_sync_ff} << `SPO_GPI_EIGHT)
                         | ({31'h0, alert_sync_ff} << `SPO_GPI_ELEVEN);
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_ff :
        hit_rate ? {16'h0000, rate_ff} :
        hit_pinsel ? pinsel_ff :
        hit_gpo ? gpo_ff :
        hit_gpi ? gpi_word :
        hit_status ? {30'h0, status_ff} :
        hit_mask ? {30'h0, mask_ff} :
        hit_state ? {26'h0, out_ff} : 32'h0000_0000;

    // Read data registered; unmapped addresses read zero.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_ff <= 32'h0000_0000;
            rd_done_ff <= 1'b0;
        end else begin
            rdata_ff <= rd_mux;
            rd_done_ff <= AVS_READ & ~rd_done_ff;
        end
    end

endmodule
`default_nettype wire

// File: test/plane_far_side.sv
// Far side model: thermal sensor and alert source.
// Assumes the bench sets its requests just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module plane_far_side (
    input wire logic hot,
    input wire logic alert,
    output logic thermal_detect_n,
    output logic bus_alert_n
);
    // sensor pulls low
    // Each source pulls its line low while it wants attention.
    assign thermal_detect_n = !hot;
    assign bus_alert_n = !alert;
endmodule
`default_nettype wire

// File: test/suspend_plane_status_outputs_monitor.sv
// Checker watching the suspend plane block at its ports.
// Assumes a bind to the top module; pin selects are mirrored off the bus.
`timescale 1ns/1ps
`default_nettype none
module suspend_plane_status_outputs_monitor (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [2:0] SUSPEND_STATE,
    input wire logic SMB_CLK_OE_N,
    input wire logic SMB_DATA_OE_N,
    input wire logic PRIMARY_PLANE_CTL_N,
    input wire logic SECONDARY_PLANE_CTL_N,
    input wire logic TERTIARY_PLANE_CTL_N,
    input wire logic HOST_CLOCK_STATUS_N,
    input wire logic SYSTEM_SUSPEND_STATUS_N,
    input wire logic CACHE_SRAM_SLEEP,
    input wire logic CPU_STOP_CLOCK_REQ_N,
    input wire logic ALERT_EVENT
);
    // ========================================
    // Helper logic
    logic [4:0] sel_ff;
    // State groups and the pin select write strobe.
    wire susp = SUSPEND_STATE inside {3'h2, 3'h3, 3'h4};
    wire deep = SUSPEND_STATE inside {3'h3, 3'h4};
    wire sel_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h08;
    // Mirror of the general-purpose selections, so muxed pins are skipped.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) sel_ff <= 5'h00;
        else if (sel_wr) sel_ff <= AVS_WRITEDATA[4:0];
    end

    // ========================================
    // Assertions
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Plane outputs lag the state by one cycle.
    sequence s_rd_ans;
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
    endsequence
    property p_rd; $rose(AVS_READ) |-> s_rd_ans; endproperty
    property p_rst;
        $fell(RESET) |-> !PRIMARY_PLANE_CTL_N && !SECONDARY_PLANE_CTL_N &&
            !TERTIARY_PLANE_CTL_N && !HOST_CLOCK_STATUS_N &&
            !SYSTEM_SUSPEND_STATUS_N && !CACHE_SRAM_SLEEP;
    endproperty
    // Attempts start only out of reset, so no check other than p_rst sees reset levels.
    property p_prim;
        !RESET |=> PRIMARY_PLANE_CTL_N == !$past(susp);
    endproperty
    property p_sec;
        !RESET |=> $past(sel_ff[0]) ||
            SECONDARY_PLANE_CTL_N == !$past(deep);
    endproperty
    property p_ter;
        !RESET |=> $past(sel_ff[1]) ||
            TERTIARY_PLANE_CTL_N == ($past(SUSPEND_STATE) != 3'h4);
    endproperty
    // Host clock may also stop while throttling drives the stop request.
    property p_hclk;
        !RESET |=> $past(sel_ff[2]) || HOST_CLOCK_STATUS_N ==
            ($past(SUSPEND_STATE) == 3'h0 && $past(CPU_STOP_CLOCK_REQ_N));
    endproperty
    property p_sysp;
        !RESET |=> $past(sel_ff[3]) ||
            SYSTEM_SUSPEND_STATUS_N == !$past(susp);
    endproperty
    property p_sram;
        !RESET |=> $past(sel_ff[4]) || $past(SUSPEND_STATE) != 3'h1 ||
            CACHE_SRAM_SLEEP;
    endproperty
    property p_sram_low;
        !RESET |=> $past(sel_ff[4]) || !$past(susp) || !CACHE_SRAM_SLEEP;
    endproperty
    property p_smb; SMB_CLK_OE_N && SMB_DATA_OE_N; endproperty
    property p_alert; ALERT_EVENT |=> !ALERT_EVENT; endproperty
    a_rd: assert property (p_rd) else $error("Read answer late");
    a_rst: assert property (p_rst) else $error("Reset level");
    a_prim: assert property (p_prim) else $error("Primary plane");
    a_sec: assert property (p_sec) else $error("Secondary plane");
    a_ter: assert property (p_ter) else $error("Tertiary plane");
    a_hclk: assert property (p_hclk) else $error("Host clock");
    a_sysp: assert property (p_sysp) else $error("Suspend status");
    a_sram: assert property (p_sram) else $error("Sram sleep");
    a_sram_low: assert property (p_sram_low) else $error("Sram awake");
    a_smb: assert property (p_smb) else $error("Bus pins driven");
    a_alert: assert property (p_alert) else $error("Alert pulse");
endmodule
bind suspend_plane_status_outputs suspend_plane_status_outputs_monitor
    i_mon (.CLK, .RESET, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_WAITREQUEST, .SUSPEND_STATE, .SMB_CLK_OE_N,
    .SMB_DATA_OE_N, .PRIMARY_PLANE_CTL_N, .SECONDARY_PLANE_CTL_N,
    .TERTIARY_PLANE_CTL_N, .HOST_CLOCK_STATUS_N, .SYSTEM_SUSPEND_STATUS_N,
    .CACHE_SRAM_SLEEP, .CPU_STOP_CLOCK_REQ_N, .ALERT_EVENT);
`default_nettype wire

// File: test/suspend_plane_status_outputs_tb.sv
// Self-checking bench for the suspend plane block.
// Assumes package, header, design, checker and far-side model compiled.
`timescale 1ns/1ps
`default_nettype none
module suspend_plane_status_outputs_tb;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic hot = 1'b0;
    logic alert = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [2:0] st = 3'h0;
    logic [31:0] rdat;
    logic [5:0] pl;
    logic wreq, thn, aln, coe, doe, stp, thr, aev, irq;
    int fails = 0;
    int n_tests = 0;

    // ========================================
    // Device and far side; bus inputs are tied to the output enables, which idle high when undriven.
    suspend_plane_status_outputs i_dut (
        .CLK(CLK), .RESET(RESET), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .SUSPEND_STATE(st),
        .THERMAL_DETECT_N(thn), .BUS_ALERT_N(aln), .SMB_CLK_IN(coe),
        .SMB_DATA_IN(doe), .SMB_CLK_OUT(), .SMB_CLK_OE_N(coe),
        .SMB_DATA_OUT(), .SMB_DATA_OE_N(doe), .PRIMARY_PLANE_CTL_N(pl[5]),
        .SECONDARY_PLANE_CTL_N(pl[4]), .TERTIARY_PLANE_CTL_N(pl[3]),
        .HOST_CLOCK_STATUS_N(pl[2]), .SYSTEM_SUSPEND_STATUS_N(pl[1]),
        .CACHE_SRAM_SLEEP(pl[0]), .CPU_STOP_CLOCK_REQ_N(stp),
        .THROTTLE_ACTIVE(thr), .ALERT_EVENT(aev), .IRQ(irq));
    plane_far_side i_far (.hot(hot), .alert(alert), .thermal_detect_n(thn),
        .bus_alert_n(aln));

    // The clock toggles every half period of 4 ns.
    always #4 CLK = ~CLK;

    // Compares one value with its expectation and counts the outcome.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Writes one register from a clock edge, held until waitrequest is low.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        adr <= a;
        wdat <= d;
        wr_en <= 1'b1;
        do @(posedge CLK); while (wreq !== 1'b0);
        wr_en <= 1'b0;
    endtask

    // Reads one register; data is taken at the edge that ends the wait.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK);
        adr <= a;
        rd_en <= 1'b1;
        do @(posedge CLK); while (wreq !== 1'b0);
        d = rdat;
        rd_en <= 1'b0;
    endtask

    // Counts cycles until the stop request changes level.
    task automatic wait_chg(output int n);
        logic v;
        v = stp;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (stp === v && n < 100);
    endtask

    // Expected levels {primary .. sram} for a state and pin selections.
    function automatic logic [5:0] exp_pl(input logic [2:0] s,
            input logic [4:0] sel, input logic [31:0] g);
        logic su;
        su = s inside {3'h2, 3'h3, 3'h4};
        return {!su, sel[0] ? g[15] : s < 3'h3, sel[1] ? g[16] : s != 3'h4,
            sel[2] ? g[20] : s == 3'h0, sel[3] ? g[21] : !su,
            sel[4] ? g[19] : s == 3'h1};
    endfunction

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Watchdog cuts a hang short after 20000 cycles.
    initial begin
        #160000;
        fails++;
        stop_test;
    end

    // Main sequence of tests.
    initial begin
        logic [31:0] d, g;
        logic [4:0] s;
        logic [2:0] q;
        int n;
        void'($urandom(32'h77317625));
        repeat (3) @(posedge CLK);
        #1;
        chk({25'h0, pl, stp}, 32'h1);
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        repeat (2) @(posedge CLK);
        #1;
        chk({26'h0, pl}, 32'h3E);
        chk({30'h0, coe, doe}, 32'h3);
        $display("Reset test done.");
        for (int i = 0; i < 24; i++) begin
            s = (i < 5) ? 5'h00 : 5'($urandom);
            q = (i < 5) ? 3'(i) : 3'($urandom_range(4));
            g = $urandom & 32'h0039_8000;
            wr(8'h08, {27'h0, s});
            wr(8'h34, g);
            st <= q;
            @(posedge CLK);
            #1;
            chk({26'h0, pl}, {26'h0, exp_pl(q, s, g)});
        end
        rd(8'h34, d);
        chk(d, g);
        rd(8'h20, d);
        chk(d, 32'h0);
        st <= 3'h0;
        wr(8'h08, 32'h0);
        $display("State test done.");
        wr(8'h04, 32'h4);
        wr(8'h00, 32'h1);
        hot <= 1'b1;
        wait_chg(n);
        wait_chg(n);
        chk(32'(n), 32'h5);
        chk({30'h0, pl[2], pl[0]}, 32'h1);
        rd(8'h0C, d);
        chk({d[1], 30'h0, irq}, 32'h8000_0000);
        wr(8'h10, 32'h2);
        @(posedge CLK);
        chk({31'h0, irq}, 32'h1);
        hot <= 1'b0;
        repeat (6) @(posedge CLK);
        chk({30'h0, thr, stp}, 32'h1);
        wr(8'h0C, 32'h2);
        @(posedge CLK);
        chk({31'h0, irq}, 32'h0);
        $display("Throttle test done.");
        wr(8'h08, 32'h60);
        wr(8'h00, 32'h3);
        hot <= 1'b1;
        alert <= 1'b1;
        repeat (8) @(posedge CLK);
        rd(8'h30, d);
        chk(d & 32'h0900, 32'h0);
        rd(8'h0C, d);
        chk({d[30:0], thr}, 32'h0);
        hot <= 1'b0;
        alert <= 1'b0;
        repeat (4) @(posedge CLK);
        rd(8'h30, d);
        chk(d & 32'h0900, 32'h0900);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h2);
        wr(8'h10, 32'h1);
        alert <= 1'b1;
        for (n = 0; n < 10 && aev !== 1'b1; n++) @(posedge CLK);
        chk({31'h0, aev}, 32'h1);
        alert <= 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        chk({31'h0, irq}, 32'h1);
        wr(8'h0C, 32'h1);
        @(posedge CLK);
        chk({31'h0, irq}, 32'h0);
        $display("Alert test done.");
        stop_test;
    end
endmodule
`default_nettype wire
